// ==== core/bank_cfg_mem.sv ====
`timescale 1ns/1ns
// Per-bank configuration store: wait states, float cycles, width, mode.
module bank_cfg_mem (
  input wire logic core_clk, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic wr_en, // Write strobe.
  input wire logic [2:0] wr_bank, // Bank written.
  input wire logic [9:0] wr_data, // Configuration word.
  input wire logic [2:0] rd_bank, // Bank read.
  output logic [9:0] rd_data // Registered configuration word.
);
  logic [9:0] mem_reg [8];
  logic [9:0] mem_next [8];
  logic [9:0] rd_data_next;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (wr_en) begin
      mem_next[wr_bank] = wr_data;
    end
    rd_data_next = mem_reg[rd_bank];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        mem_reg[i] <= 10'h000;
      end
      rd_data <= 10'h000;
    end else begin
      mem_reg <= mem_next;
      rd_data <= rd_data_next;
    end
  end
endmodule : bank_cfg_mem

// ==== core/boot_remap_bus_decode.sv ====
`timescale 1ns/1ns
`include "boot_remap_map.svh"
module boot_remap_bus_decode
  import boot_remap_pkg::*;
(
  input wire logic core_clk, // System clock.
  input wire logic rst, // Internal reset, synchronous.
  input wire logic ext_reset_pin_n, // External reset pin.
  input wire logic boot_width_select, // Boot width strap pin.
  input wire logic acc_valid, // Core access request.
  input wire logic acc_write, // Write access.
  input wire logic [1:0] acc_size, // Byte, half or word.
  input wire logic [31:0] acc_addr, // Core address.
  input wire logic [31:0] acc_wdata, // Core write data.
  input wire logic remap_wr, // Write to remap control register.
  input wire logic [1:0] layout_cfg, // Bank layout.
  input wire logic cfg_wr, // Bank configuration write.
  input wire logic [2:0] cfg_bank, // Bank written.
  input wire logic [9:0] cfg_data, // Wait, float, width, mode, early.
  input wire logic [31:0] cmd_wr_data, // Command register write.
  input wire logic cmd_wr, // Command register strobe.
  input wire logic [31:0] mode_wdata, // Configuration register data.
  input wire logic mode_wr, // Configuration register strobe.
  input wire logic [31:0] stat_set, // Status set register write.
  input wire logic [31:0] stat_clr, // Status clear register write.
  input wire logic [31:0] stat_hw_set, // Peripheral status events.
  input wire logic [31:0] mask_set, // Mask set register write.
  input wire logic [31:0] mask_clr, // Mask clear register write.
  output logic remap_done, // Remap in force.
  output logic boot_8bit, // Sampled boot width is 8 bits.
  output logic [1:0] region, // Decoded region.
  output logic sram_sel, // Internal SRAM selected.
  output logic boot_sel, // Boot device selected.
  output logic [7:0] chip_select_zero_n, // External selects, low active.
  output logic ext_sel, // External bus unit selected.
  output logic periph_sel, // Peripheral bus selected.
  output logic irqctl_sel, // Interrupt controller window.
  output logic [3:0] periph_idx, // Peripheral window index.
  output logic [31:0] out_addr, // Routed address.
  output logic abort, // Abort to core.
  output logic [3:0] wait_cnt, // Wait states of selected bank.
  output logic [2:0] float_cnt, // Float cycles of selected bank.
  output logic bus16, // Selected bank is 16 bits wide.
  output logic byte_write_mode, // Two 8-bit devices paired.
  output logic early_read, // Early read enabled.
  output logic [31:0] cmd_pulse, // Command pulses.
  output logic [31:0] mode_rdata, // Configuration register.
  output logic [31:0] status_rdata, // Status register.
  output logic [31:0] mask_rdata, // Mask register.
  output logic irq_source // Interrupt source.
);
  logic rstn_s1_reg, rstn_s2_reg, bws_s1_reg, bws_s2_reg;
  logic remap_reg, remap_next, boot8_reg, boot8_next;
  logic [3:0] hi_seen_reg, hi_seen_next;
  logic [1:0] region_next;
  logic sram_next, boot_next, ext_next, periph_next, irqctl_next, abort_next;
  logic [7:0] cs_next;
  logic [3:0] pidx_next;
  logic [31:0] addr_next;
  logic [31:0] cmd_next, mode_next, status_next, mask_next;
  logic irq_next;
  logic [9:0] bank_rd;
  logic [2:0] bank_idx;
  logic any_rst;

  assign any_rst = rst | ~rstn_s2_reg;

  function automatic logic [2:0] bank_of(input logic [31:0] a,
                                         input logic [1:0] lay);
    logic [2:0] b;
    logic [31:0] o;
    b = 3'h0;
    // Banks count up from the bottom of the external space.
    o = a - `EXT_SPACE_LO;
    unique case (lay)
      2'b00: b = o[22:20];
      2'b01: b = o[24:22];
      2'b10: b = {1'b0, o[24:23]};
      2'b11: b = {1'b0, o[25:24]};
    endcase
    return b;
  endfunction : bank_of

  function automatic logic bank_defined(input logic [31:0] a,
                                        input logic [1:0] lay);
    logic ok;
    logic [31:0] o;
    ok = 1'b0;
    o = a - `EXT_SPACE_LO;
    unique case (lay)
      2'b00: ok = (o[31:23] == 9'h000);
      2'b01: ok = (o[31:25] == 7'h00);
      2'b10: ok = (o[31:25] == 7'h00);
      2'b11: ok = (o[31:26] == 6'h00);
    endcase
    return ok;
  endfunction : bank_defined

  bank_cfg_mem u_cfg (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(cfg_wr),
    .wr_bank(cfg_bank),
    .wr_data(cfg_data),
    .rd_bank(bank_idx),
    .rd_data(bank_rd)
  );

  always_ff @(posedge core_clk) begin
    rstn_s1_reg <= ext_reset_pin_n;
    rstn_s2_reg <= rstn_s1_reg;
    bws_s1_reg <= boot_width_select;
    bws_s2_reg <= bws_s1_reg;
  end

  // Strap sampling: 8-bit boot only if high for the last ten clocks.
  always_comb begin
    hi_seen_next = hi_seen_reg;
    boot8_next = boot8_reg;
    remap_next = remap_reg;
    if (!rstn_s2_reg) begin
      if (!bws_s2_reg) begin
        hi_seen_next = 4'h0;
      end else if (hi_seen_reg != `BOOT_SAMPLE_CLKS) begin
        hi_seen_next = hi_seen_reg + 4'h1;
      end
      boot8_next = (hi_seen_next == `BOOT_SAMPLE_CLKS);
      remap_next = 1'b0;
    end else begin
      // A fresh count starts with every pin reset.
      hi_seen_next = 4'h0;
      if (rst) begin
        remap_next = 1'b0;
      end else if (remap_wr && acc_wdata[`REMAP_BIT_POS]) begin
        remap_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    hi_seen_reg <= hi_seen_next;
    boot8_reg <= boot8_next;
    remap_reg <= remap_next;
  end

  // Address decode and routing.
  always_comb begin
    bank_idx = bank_of(acc_addr, layout_cfg);
    region_next = REGION_INTERNAL;
    sram_next = 1'b0;
    boot_next = 1'b0;
    ext_next = 1'b0;
    periph_next = 1'b0;
    irqctl_next = 1'b0;
    abort_next = 1'b0;
    cs_next = 8'hFF;
    pidx_next = 4'h0;
    addr_next = acc_addr;
    if (acc_valid) begin
      if (acc_addr < `EXT_SPACE_LO) begin
        region_next = REGION_INTERNAL;
        if (remap_reg) begin
          sram_next = 1'b1;
        end else begin
          boot_next = 1'b1;
          cs_next = 8'hFE;
        end
      end else if (acc_addr < `EXT_SPACE_HI) begin
        region_next = REGION_EXTERNAL;
        ext_next = 1'b1;
        // Selects above zero exist only after remap.
        if (!bank_defined(acc_addr, layout_cfg) ||
            (!remap_reg && bank_idx != 3'h0)) begin
          abort_next = 1'b1;
        end else begin
          cs_next = ~(8'h01 << bank_idx);
        end
      end else begin
        region_next = REGION_PERIPH;
        periph_next = 1'b1;
        addr_next = acc_addr & `REG_WORD_MASK;
        irqctl_next = (acc_addr >= `IRQCTL_WIN_BASE);
        pidx_next = acc_addr[`PERIPH_WIN_SHIFT +: 4];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      region <= 2'b00;
      sram_sel <= 1'b0;
      boot_sel <= 1'b0;
      ext_sel <= 1'b0;
      periph_sel <= 1'b0;
      irqctl_sel <= 1'b0;
      abort <= 1'b0;
      chip_select_zero_n <= 8'hFF;
      periph_idx <= 4'h0;
      out_addr <= 32'h0000_0000;
    end else begin
      region <= region_next;
      sram_sel <= sram_next;
      boot_sel <= boot_next;
      ext_sel <= ext_next;
      periph_sel <= periph_next;
      irqctl_sel <= irqctl_next;
      abort <= abort_next;
      chip_select_zero_n <= cs_next;
      periph_idx <= pidx_next;
      out_addr <= addr_next;
    end
  end

  // Bank timing comes out of the store one cycle after the decode.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wait_cnt <= 4'h0;
      float_cnt <= 3'h0;
      bus16 <= 1'b0;
      byte_write_mode <= 1'b0;
      early_read <= 1'b0;
    end else begin
      wait_cnt <= bank_rd[3:0];
      float_cnt <= bank_rd[6:4];
      bus16 <= (!remap_reg && !boot8_reg) | bank_rd[7];
      byte_write_mode <= bank_rd[8];
      early_read <= bank_rd[9];
    end
  end

  // Common peripheral register set.
  always_comb begin
    cmd_next = cmd_wr ? cmd_wr_data : 32'h0000_0000;
    mode_next = mode_wr ? mode_wdata : mode_rdata;
    // Hardware and set writes win over a clear in the same cycle.
    status_next = (status_rdata & ~stat_clr) | stat_set | stat_hw_set;
    mask_next = (mask_rdata & ~mask_clr) | mask_set;
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      cmd_pulse <= 32'h0000_0000;
      mode_rdata <= `CFG_RESET;
      status_rdata <= 32'h0000_0000;
      mask_rdata <= 32'h0000_0000;
      irq_source <= 1'b0;
    end else begin
      cmd_pulse <= cmd_next;
      mode_rdata <= mode_next;
      status_rdata <= status_next;
      mask_rdata <= mask_next;
      irq_source <= irq_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      remap_done <= 1'b0;
      boot_8bit <= 1'b0;
    end else begin
      remap_done <= remap_reg;
      boot_8bit <= boot8_reg;
    end
  end

  chk_remap_sticks: assert property (
    @(posedge core_clk) disable iff (rst)
    remap_reg && rstn_s2_reg |=> remap_reg)
    else $error("remap dropped without reset");
  chk_remap_sets: assert property (
    @(posedge core_clk) disable iff (rst)
    remap_wr && acc_wdata[0] && rstn_s2_reg |=> remap_reg)
    else $error("remap command ignored");
  chk_no_int_abort: assert property (
    @(posedge core_clk) disable iff (rst)
    acc_valid && (acc_addr < 32'h0040_0000 || acc_addr >= 32'hFFC0_0000)
    |=> !abort)
    else $error("abort on internal access");
  chk_ext_route: assert property (
    @(posedge core_clk) disable iff (rst)
    acc_valid && acc_addr >= 32'h0040_0000 && acc_addr < 32'hFFC0_0000
    |=> ext_sel && region == 2'b01)
    else $error("external access not routed");
  chk_undef_abort: assert property (
    @(posedge core_clk) disable iff (rst)
    acc_valid && acc_addr >= 32'h0440_0000 && acc_addr < 32'hFFC0_0000
    |=> abort)
    else $error("undefined external address without abort");
  chk_word_mask: assert property (
    @(posedge core_clk) disable iff (rst)
    acc_valid && acc_addr >= 32'hFFC0_0000 |=> out_addr[1:0] == 2'b00)
    else $error("peripheral address not word aligned");
  chk_irq_and_or: assert property (
    @(posedge core_clk) disable iff (any_rst)
    irq_source == |(status_rdata & mask_rdata))
    else $error("interrupt source mismatch");
  chk_sram_zero: assert property (
    @(posedge core_clk) disable iff (rst)
    acc_valid && acc_addr < 32'h0000_0020 && remap_reg
    |=> sram_sel && !boot_sel)
    else $error("sram not at zero after remap");
  chk_boot_zero: assert property (
    @(posedge core_clk) disable iff (rst)
    acc_valid && acc_addr < 32'h0040_0000 && !remap_reg
    |=> boot_sel && chip_select_zero_n == 8'hFE)
    else $error("boot device not at zero before remap");
  chk_cmd_pulse: assert property (
    @(posedge core_clk) disable iff (any_rst)
    !cmd_wr |=> cmd_pulse == 32'h0000_0000)
    else $error("command pulse without write");
endmodule : boot_remap_bus_decode

// ==== core/boot_remap_map.svh ====
`ifndef BOOT_REMAP_MAP_SVH
`define BOOT_REMAP_MAP_SVH
`define VEC_TABLE_END 32'h0000_0020
`define EXT_SPACE_LO 32'h0040_0000
`define EXT_SPACE_HI 32'hFFC0_0000
`define INT_SRAM_BYTES 32'h0004_0000
`define PERIPH_WIN_SHIFT 14
`define IRQCTL_WIN_BASE 32'hFFFF_F000
`define BOOT_SAMPLE_CLKS 4'hA
`define REMAP_BIT_POS 0
`define CFG_RESET 32'h0000_0000
`define REG_WORD_MASK 32'hFFFF_FFFC
`endif

// ==== core/boot_remap_pkg.sv ====
package boot_remap_pkg;
  typedef enum logic [1:0] {
    REGION_INTERNAL = 2'b00,
    REGION_EXTERNAL = 2'b01,
    REGION_PERIPH = 2'b10
  } region_t;
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_HALF = 2'b01,
    SIZE_WORD = 2'b10
  } access_size_t;
  typedef enum logic [1:0] {
    LAYOUT_8X1M = 2'b00,
    LAYOUT_8X4M = 2'b01,
    LAYOUT_4X8M = 2'b10,
    LAYOUT_4X16M = 2'b11
  } bank_layout_t;
endpackage : boot_remap_pkg

// ==== tb/core_access_model.sv ====
`timescale 1ns/1ns
// Core side: each call that software does not hold off drives one access for exactly one sampling edge.
module core_access_model
  import boot_remap_pkg::*;
(
  input wire logic core_clk, // System clock.
  input wire logic remap_done, // Remap state seen by software.
  output logic acc_valid, // Access request.
  output logic acc_write, // Write access.
  output logic [1:0] acc_size, // Access size.
  output logic [31:0] acc_addr, // Access address.
  output logic [31:0] acc_wdata, // Write data.
  output logic remap_wr // Remap control write.
);
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_size = SIZE_WORD;
    acc_addr = 32'h0000_0000;
    acc_wdata = 32'h0000_0000;
    remap_wr = 1'b0;
  end
  task automatic access(input logic w, input logic [1:0] sz,
    input logic [31:0] a, input logic [31:0] d, input logic rm,
    input logic brk);
    // Software keeps off the later selects until remap, unless told not to.
    if (!remap_done && a >= 32'h0050_0000 && a < 32'hFFC0_0000 && !brk)
      return;
    @(posedge core_clk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_size <= sz;
    acc_addr <= a;
    acc_wdata <= (sz == SIZE_BYTE) ? {24'h00_0000, d[7:0]} :
      (sz == SIZE_HALF) ? {16'h0000, d[15:0]} : d;
    remap_wr <= rm;
    @(posedge core_clk);
    acc_valid <= 1'b0;
    remap_wr <= 1'b0;
    acc_addr <= ~a;
    acc_wdata <= ~d;
    #1;
  endtask : access
endmodule : core_access_model

// ==== tb/test_boot_remap_bus_decode.sv ====
`timescale 1ns/1ns
module test_boot_remap_bus_decode;
  import boot_remap_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, ext_reset_pin_n = 1'b1;
  logic boot_width_select = 1'b0, remap_wr, acc_valid, acc_write;
  logic [1:0] acc_size, region, layout_cfg = 2'b00;
  logic [31:0] acc_addr, acc_wdata, cmd_wr_data = '0, mode_wdata = '0;
  logic cfg_wr = 1'b0, cmd_wr = 1'b0, mode_wr = 1'b0;
  logic [2:0] cfg_bank = 3'h0, float_cnt;
  logic [9:0] cfg_data = 10'h000;
  logic [31:0] stat_set = '0, stat_clr = '0, stat_hw_set = '0;
  logic [31:0] mask_set = '0, mask_clr = '0, out_addr, cmd_pulse;
  logic [31:0] mode_rdata, status_rdata, mask_rdata;
  logic remap_done, boot_8bit, sram_sel, boot_sel, ext_sel, periph_sel;
  logic irqctl_sel, abort, bus16, byte_write_mode, early_read, irq_source;
  logic [7:0] chip_select_zero_n;
  logic [3:0] periph_idx, wait_cnt;
  logic [31:0] seed = 32'h0000_4E30, a, st, mk, s, c, h, ms, mc, md, cm;
  int err_count = 0, n_checks = 0, sh, n;
  always #10 core_clk = ~core_clk;
  boot_remap_bus_decode dut (.core_clk, .rst, .ext_reset_pin_n,
    .boot_width_select, .acc_valid, .acc_write, .acc_size, .acc_addr,
    .acc_wdata, .remap_wr, .layout_cfg, .cfg_wr, .cfg_bank, .cfg_data,
    .cmd_wr_data, .cmd_wr, .mode_wdata, .mode_wr, .stat_set, .stat_clr,
    .stat_hw_set, .mask_set, .mask_clr, .remap_done, .boot_8bit, .region,
    .sram_sel, .boot_sel, .chip_select_zero_n, .ext_sel, .periph_sel,
    .irqctl_sel, .periph_idx, .out_addr, .abort, .wait_cnt, .float_cnt,
    .bus16, .byte_write_mode, .early_read, .cmd_pulse, .mode_rdata,
    .status_rdata, .mask_rdata, .irq_source);
  core_access_model core (.core_clk, .remap_done, .acc_valid, .acc_write,
    .acc_size, .acc_addr, .acc_wdata, .remap_wr);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic pinrst(input logic b);
    @(posedge core_clk);
    ext_reset_pin_n <= 1'b0;
    boot_width_select <= b;
    repeat (12) @(posedge core_clk);
    ext_reset_pin_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(32'(boot_8bit), 32'(b));
    chk(32'(remap_done), 32'h0000_0000);
  endtask : pinrst
  task automatic pulse(input logic mw);
    @(posedge core_clk);
    stat_set <= s;
    stat_clr <= c;
    stat_hw_set <= h;
    mask_set <= ms;
    mask_clr <= mc;
    cmd_wr_data <= cm;
    cmd_wr <= 1'b1;
    mode_wdata <= md;
    mode_wr <= mw;
    @(posedge core_clk);
    {stat_set, stat_clr, stat_hw_set, mask_set, mask_clr} <= '0;
    cmd_wr <= 1'b0;
    mode_wr <= 1'b0;
    #1;
  endtask : pulse
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    #200_000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk(mode_rdata, 32'h0000_0000);
    pinrst(1'b1);
    pinrst(1'b0);
    core.access(1'b0, SIZE_WORD, 32'h0000_0010, '0, 1'b0, 1'b0);
    chk(32'({boot_sel, sram_sel, abort}), 32'h0000_0004);
    core.access(1'b0, SIZE_WORD, 32'h0050_0000, '0, 1'b0, 1'b1);
    chk(32'(abort), 32'h0000_0001);
    core.access(1'b1, SIZE_WORD, 32'hFFE0_0000, 32'h1, 1'b1, 1'b0);
    core.access(1'b1, SIZE_WORD, 32'hFFE0_0000, 32'h0, 1'b1, 1'b0);
    chk(32'(remap_done), 32'h0000_0001);
    core.access(1'b0, SIZE_WORD, 32'h0000_001C, '0, 1'b0, 1'b0);
    chk(32'({boot_sel, sram_sel}), 32'h0000_0001);
    $display("test boot and remap done");
    for (int l = 0; l < 4; l++) begin
      sh = (l == 0) ? 20 : (l == 1) ? 22 : (l == 2) ? 23 : 24;
      n = (l < 2) ? 8 : 4;
      @(posedge core_clk);
      layout_cfg <= 2'(l);
      for (int j = 0; j < 5; j++) begin
        a = 32'h0040_0000 + ((j == 0) ? (n << sh) - 1 : rnd() % (n << sh));
        core.access(1'b0, 2'(rnd() % 3), a, rnd(), 1'b0, 1'b0);
        chk(32'({ext_sel, region, abort}), 32'h0000_000A);
        chk(32'(8'hFF ^ chip_select_zero_n),
          32'h0000_0001 << ((a - 32'h0040_0000) >> sh));
      end
      a = 32'h0040_0000 + (n << sh);
      core.access(1'b0, SIZE_WORD, a, '0, 1'b0, 1'b0);
      chk(32'(abort), 32'h0000_0001);
    end
    for (int b = 0; b < 8; b++) begin
      md = rnd();
      @(posedge core_clk);
      layout_cfg <= LAYOUT_8X1M;
      cfg_wr <= 1'b1;
      cfg_bank <= 3'(b);
      cfg_data <= md[9:0];
      @(posedge core_clk);
      cfg_wr <= 1'b0;
      core.access(1'b0, SIZE_HALF, 32'h0040_0000 + (b << 20), '0, 0, 0);
      @(posedge core_clk);
      #1;
      chk(32'({early_read, byte_write_mode, bus16, float_cnt, wait_cnt}),
        32'(md[9:0]));
    end
    for (int j = 0; j < 8; j++) begin
      a = 32'hFFC0_0000 + rnd() % 32'h003F_F000;
      core.access(1'b0, 2'(j % 2), a, '0, 1'b0, 1'b0);
      chk(out_addr, a & 32'hFFFF_FFFC);
      chk(32'({periph_sel, region, abort}), 32'h0000_000C);
      chk(32'(periph_idx), 32'(a[17:14]));
      a = (j == 0) ? 32'h003F_FFFF : rnd() & 32'h003F_FFFF;
      core.access(1'b0, SIZE_BYTE, a, '0, 1'b0, 1'b0);
      chk(32'({region, abort}), 32'h0000_0000);
    end
    core.access(1'b0, SIZE_WORD, 32'hFFFF_F123, '0, 1'b0, 1'b0);
    chk(32'(irqctl_sel), 32'h0000_0001);
    $display("test decode done");
    st = '0;
    mk = '0;
    for (int j = 0; j < 10; j++) begin
      s = (j == 0) ? '0 : rnd() & rnd();
      c = (j == 0) ? '1 : rnd();
      h = rnd() & rnd() & rnd();
      ms = rnd();
      mc = rnd();
      md = rnd();
      cm = rnd();
      st = (st & ~c) | s | h;
      mk = (mk & ~mc) | ms;
      pulse(1'b1);
      chk(status_rdata, st);
      chk(mask_rdata, mk);
      chk(32'(irq_source), 32'(|(st & mk)));
      chk(cmd_pulse, cm);
      chk(mode_rdata, md);
      @(posedge core_clk);
      #1;
      chk(cmd_pulse, 32'h0000_0000);
    end
    $display("test registers done");
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(32'(remap_done), 32'h0000_0000);
    core.access(1'b1, SIZE_WORD, 32'hFFE0_0000, 32'h1, 1'b1, 1'b0);
    pinrst(1'b1);
    $display("test resets done");
    summarize();
  end
endmodule : test_boot_remap_bus_decode
